// [src/tv_sound_control_registers.sv]
// serial control and status register bank of the tv sound decoder
//
// Contract
// - power-on reset clears mute bit, mute active
// - routing bit 0 zero mutes outputs
// - register 0 six-bit input level trim
// - register 0 bit 6 picks noise stop
// - stereo oscillator trim, fh monitor on right
// - filter trim, pilot canceller enabled at zero
// - low and high band separation trims
// - sap oscillator trim, 5fh monitor on right
// - forced mono puts mono on both outputs
// - routing bit 2 picks stereo or sap
// - routing bit 3 picks sap variant
// - routing bit 4 normal source sap/mono
// - routing bit 5 internal or external sap
// - forced mono gives mono on normal output unless routing bit 5 alone picks external sap
// - sap switch steers normal only when selected
// - status bit 4 reports detected noise
// - status bit 7 reports power-on reset
// - status bits 6,5 report pilot and sap
// - status bit 3 reports stereo reception
// - status bit 2 reports sap reception
// - slave address 1000111 plus direction bit
// - write: subaddress byte then data
// - subaddress advances after each data byte
// - read returns single status byte
`include "tv_sound_params.svh"
`timescale 1ns/100ps
`default_nettype none

module tv_sound_control_registers
  import tv_sound_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // detector inputs
  input  wire logic       pilot_present_i,
  input  wire logic       second_program_present_i,
  input  wire logic       noise_present_i,
  // trims and switches
  output logic [5:0]      input_level_trim_o,
  output logic [5:0]      stereo_osc_trim_o,
  output logic [5:0]      filter_trim_o,
  output logic [5:0]      low_band_sep_trim_o,
  output logic [5:0]      high_band_sep_trim_o,
  output logic [5:0]      second_program_osc_trim_o,
  output logic            pilot_cancel_en_o,
  // output routing
  output source_t         left_audio_out_sel_o,
  output source_t         right_audio_out_sel_o,
  output source_t         normal_out_sel_o,
  output logic [7:0]      detection_status_o
);

  core_t s;
  core_t next_s;

  // noise stop of stereo only, sap is stopped by noise alone
  function automatic logic noise_stop_all(input core_t c);
    return c.det_s2.noise & c.wreg[`TVS_REG_LEVEL][`TVS_BIT_D6];
  endfunction : noise_stop_all

  // sap carrier usable while quiet
  function automatic logic sap_usable(input core_t c);
    return c.det_s2.second_program & ~c.det_s2.noise;
  endfunction : sap_usable

  // stereo pilot usable unless stopped
  function automatic logic stereo_usable(input core_t c);
    return c.det_s2.pilot & ~noise_stop_all(c);
  endfunction : stereo_usable

  // status byte from state
  function automatic logic [7:0] status_byte(input core_t c);
    logic [7:0] r;
    logic       stereo_ok;
    logic       sap_ok;
    logic [7:0] rt;
    rt        = c.wreg[`TVS_REG_ROUTING];
    stereo_ok = stereo_usable(c);
    sap_ok    = sap_usable(c);
    r[7] = c.por_seen;
    r[6] = stereo_ok;
    r[5] = sap_ok;
    r[4] = c.det_s2.noise;
    r[3] = stereo_ok & ~rt[`TVS_BIT_FORCE_MONO] & ~rt[`TVS_BIT_SAP_SEL];
    r[2] = sap_ok & ~rt[`TVS_BIT_FORCE_MONO] & rt[`TVS_BIT_SAP_SEL];
    r[1:0] = 2'h3;
    return r;
  endfunction : status_byte

  // left and right program before monitors
  function automatic route_t program_route(input core_t c);
    route_t     r;
    logic [7:0] rt;
    r  = '{left_audio_out: SRC_MONO, right_audio_out: SRC_MONO, normal_out: SRC_MONO};
    rt = c.wreg[`TVS_REG_ROUTING];
    if (rt[`TVS_BIT_FORCE_MONO]) begin
      r.left_audio_out  = SRC_MONO;
      r.right_audio_out = SRC_MONO;
    end else if (rt[`TVS_BIT_SAP_SEL]) begin
      if (!sap_usable(c)) begin
        r.left_audio_out  = SRC_MONO;
        r.right_audio_out = SRC_MONO;
      end else if (rt[`TVS_BIT_SAP_VARIANT]) begin
        r.left_audio_out  = SRC_MONO;
        r.right_audio_out = SRC_SAP;
      end else begin
        r.left_audio_out  = SRC_SAP;
        r.right_audio_out = SRC_SAP;
      end
    // noise stop falls back to mono
    end else if (stereo_usable(c)) begin
      r.left_audio_out  = SRC_STEREO;
      r.right_audio_out = SRC_STEREO;
    end else begin
      r.left_audio_out  = SRC_MONO;
      r.right_audio_out = SRC_MONO;
    end
    return r;
  endfunction : program_route

  // source of the normal output
  function automatic source_t normal_source(input core_t c);
    logic [7:0] rt;
    source_t    n;
    rt = c.wreg[`TVS_REG_ROUTING];
    // weak field forces mono
    if (c.det_s2.noise) begin
      n = SRC_MONO;
    end else if (rt[`TVS_BIT_NORM_SEL2]) begin
      n = SRC_MONO;
    end else if (rt[`TVS_BIT_NORM_SEL1]) begin
      n = SRC_EXT_SAP;
    end else if (rt[`TVS_BIT_FORCE_MONO]) begin
      n = SRC_MONO;
    end else if (rt[`TVS_BIT_SAP_SEL] & sap_usable(c)) begin
      n = SRC_SAP;
    end else begin
      n = SRC_MONO;
    end
    return n;
  endfunction : normal_source

  // routing from registers and detectors
  function automatic route_t route_of(input core_t c);
    route_t     r;
    logic [7:0] rt;
    rt           = c.wreg[`TVS_REG_ROUTING];
    r            = program_route(c);
    r.normal_out = normal_source(c);
    // fh monitor wins over 5fh monitor
    // fh monitor on right
    if (c.wreg[`TVS_REG_STEREO_OSC][`TVS_BIT_D6]) begin
      r.right_audio_out = SRC_FH_MON;
    end else if (c.wreg[`TVS_REG_SAP_OSC][`TVS_BIT_D6]) begin
      r.right_audio_out = SRC_FH5_MON;
    end
    if (!rt[`TVS_BIT_MUTE]) begin
      r.left_audio_out  = SRC_MUTE;
      r.right_audio_out = SRC_MUTE;
      r.normal_out      = SRC_MUTE;
    end
    return r;
  endfunction : route_of

  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       byte_done;
    logic [7:0] stat;
    scl_rise   = 1'b0;
    scl_fall   = 1'b0;
    start_seen = 1'b0;
    stop_seen  = 1'b0;
    byte_done  = 1'b0;
    stat       = 8'h00;
    next_s = s;
    // two-flop pin synchronisers
    next_s.scl_s1 = scl_i;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_q  = s.scl_s2;
    next_s.sda_s1 = sda_i;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_q  = s.sda_s2;
    next_s.det_s1 = '{pilot: pilot_present_i,
                      second_program: second_program_present_i,
                      noise: noise_present_i};
    next_s.det_s2 = s.det_s1;
    scl_rise   = s.scl_s2 & ~s.scl_q;
    scl_fall   = ~s.scl_s2 & s.scl_q;
    start_seen = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
    stop_seen  = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
    byte_done  = scl_fall & (s.cnt == `TVS_BYTE_BITS);
    stat       = status_byte(s);
    if (scl_rise) begin
      next_s.cnt = s.cnt + 4'h1;
      if (s.st != ST_RDATA) begin
        next_s.shift = {s.shift[6:0], s.sda_s2};
      end
    end
    if (start_seen) begin
      next_s.st        = ST_ADDR;
      next_s.cnt       = 4'h0;
      next_s.sda_drive = 1'b0;
    end else if (stop_seen) begin
      next_s.st        = ST_IDLE;
      next_s.sda_drive = 1'b0;
    end else begin
      case (s.st)
        ST_ADDR: begin
          if (byte_done) begin
            if (s.shift[7:1] == `TVS_SLAVE_ADDR) begin
              next_s.st        = ST_ADDR_ACK;
              next_s.is_read   = s.shift[0];
              next_s.sda_drive = 1'b1;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.cnt = 4'h0;
            if (s.is_read) begin
              next_s.st        = ST_RDATA;
              next_s.shift     = {stat[6:0], 1'b0};
              next_s.sda_drive = ~stat[7];
            end else begin
              next_s.st        = ST_SUB;
              next_s.sda_drive = 1'b0;
            end
          end
        end
        ST_SUB: begin
          if (byte_done) begin
            next_s.sub       = s.shift;
            next_s.st        = ST_SUB_ACK;
            next_s.sda_drive = 1'b1;
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_s.st        = ST_WDATA;
            next_s.cnt       = 4'h0;
            next_s.sda_drive = 1'b0;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            if (s.sub < `TVS_REG_COUNT) begin
              next_s.wreg[s.sub[2:0]] = s.shift;
            end
            next_s.sub       = s.sub + 8'h01;
            next_s.st        = ST_WDATA_ACK;
            next_s.sda_drive = 1'b1;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            next_s.st        = ST_RACK;
            next_s.sda_drive = 1'b0;
            next_s.por_seen  = 1'b0;
          end else if (scl_fall) begin
            next_s.sda_drive = ~s.shift[7];
            next_s.shift     = {s.shift[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            next_s.st = ST_IDLE;
          end
        end
        ST_IDLE: begin
          next_s.sda_drive = 1'b0;
        end
        default: begin
          next_s.st        = ST_IDLE;
          next_s.sda_drive = 1'b0;
        end
      endcase
    end
    next_s.route = route_of(s);
    // status byte held in flops
    next_s.status = status_byte(s);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.scl_s1   <= 1'b1;
      s.scl_s2   <= 1'b1;
      s.scl_q    <= 1'b1;
      s.sda_s1   <= 1'b1;
      s.sda_s2   <= 1'b1;
      s.sda_q    <= 1'b1;
      s.por_seen <= 1'b1;
      s.cnt       <= 4'h0;
      s.shift     <= 8'h00;
      s.sub       <= 8'h00;
      s.is_read   <= 1'b0;
      s.sda_drive <= 1'b0;
      s.det_s1    <= '0;
      s.det_s2    <= '0;
      s.status    <= `TVS_STATUS_RESET;
      s.wreg     <= {7{`TVS_WREG_RESET}};
      s.wreg[`TVS_REG_ROUTING][`TVS_BIT_MUTE] <= `TVS_MUTE_RESET;
      s.route    <= '{left_audio_out: SRC_MUTE, right_audio_out: SRC_MUTE,
                      normal_out: SRC_MUTE};
    end else begin
      s <= next_s;
    end
  end

  // open-drain data pin, drives low only
  assign sda_o    = 1'b0;
  assign sda_oe_o = s.sda_drive;

  assign input_level_trim_o        = s.wreg[`TVS_REG_LEVEL][`TVS_TRIM_MSB:0];
  assign stereo_osc_trim_o         = s.wreg[`TVS_REG_STEREO_OSC][`TVS_TRIM_MSB:0];
  assign filter_trim_o             = s.wreg[`TVS_REG_FILTER][`TVS_TRIM_MSB:0];
  assign low_band_sep_trim_o       = s.wreg[`TVS_REG_LOW_SEP][`TVS_TRIM_MSB:0];
  assign high_band_sep_trim_o      = s.wreg[`TVS_REG_HIGH_SEP][`TVS_TRIM_MSB:0];
  assign second_program_osc_trim_o = s.wreg[`TVS_REG_SAP_OSC][`TVS_TRIM_MSB:0];
  assign pilot_cancel_en_o         = ~s.wreg[`TVS_REG_FILTER][`TVS_BIT_D6];
  assign left_audio_out_sel_o      = s.route.left_audio_out;
  assign right_audio_out_sel_o     = s.route.right_audio_out;
  assign normal_out_sel_o          = s.route.normal_out;
  assign detection_status_o        = s.status;

endmodule : tv_sound_control_registers

`default_nettype wire

// [src/tv_sound_params.svh]
// constants of the sound control register bank
`ifndef TV_SOUND_PARAMS_SVH
`define TV_SOUND_PARAMS_SVH

// serial bus slave address, seven bits
`define TVS_SLAVE_ADDR       7'h47
// write register offsets
`define TVS_REG_LEVEL        8'h00
`define TVS_REG_STEREO_OSC   8'h01
`define TVS_REG_FILTER       8'h02
`define TVS_REG_LOW_SEP      8'h03
`define TVS_REG_HIGH_SEP     8'h04
`define TVS_REG_SAP_OSC      8'h05
`define TVS_REG_ROUTING      8'h06
`define TVS_REG_COUNT        8'h07
// field positions
`define TVS_TRIM_MSB         5
`define TVS_BIT_D6           6
`define TVS_BIT_MUTE         0
`define TVS_BIT_FORCE_MONO   1
`define TVS_BIT_SAP_SEL      2
`define TVS_BIT_SAP_VARIANT  3
`define TVS_BIT_NORM_SEL2    4
`define TVS_BIT_NORM_SEL1    5
// reset values
`define TVS_WREG_RESET       8'h00
`define TVS_MUTE_RESET       1'b0
`define TVS_STATUS_RESET     8'h83
// bits of one serial byte
`define TVS_BYTE_BITS        4'h8

`endif

// [src/tv_sound_pkg.sv]
// types of the sound control register bank
package tv_sound_pkg;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_SUB       = 9'h008,
    ST_SUB_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } bus_state_t;

  typedef enum logic [2:0] {
    SRC_MUTE       = 3'h0,
    SRC_MONO       = 3'h1,
    SRC_STEREO     = 3'h2,
    SRC_SAP        = 3'h3,
    SRC_EXT_SAP    = 3'h4,
    SRC_FH_MON     = 3'h5,
    SRC_FH5_MON    = 3'h6
  } source_t;

  typedef struct packed {
    source_t left_audio_out;
    source_t right_audio_out;
    source_t normal_out;
  } route_t;

  typedef struct packed {
    logic pilot;
    logic second_program;
    logic noise;
  } detect_t;

  typedef struct packed {
    bus_state_t     st;
    logic [7:0]     shift;
    logic [3:0]     cnt;
    logic [7:0]     sub;
    logic           is_read;
    logic           sda_drive;
    logic           scl_s1;
    logic           scl_s2;
    logic           scl_q;
    logic           sda_s1;
    logic           sda_s2;
    logic           sda_q;
    detect_t        det_s1;
    detect_t        det_s2;
    logic           por_seen;
    logic [7:0]     status;
    logic [6:0][7:0] wreg;
    route_t         route;
  } core_t;

endpackage : tv_sound_pkg

// [tb/tb_top.sv]
// self-checking bench for the sound control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tv_sound_pkg::*;
  logic       core_clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       pilot = 1'h0;
  logic       sap = 1'h0;
  logic       noise = 1'h0;
  logic       scl, host_oe, dev_oe, sda, pce, ok, sda_out;
  logic [5:0] trim [6];
  logic [7:0] status, rd;
  source_t    lft, rgt, nrm;
  int         error_cnt = 0;
  int         check_count = 0;
  localparam logic [7:0] RW [6] = '{8'h03, 8'h05, 8'h0d, 8'h21, 8'h15, 8'h01};
  localparam logic [7:0] RS [6] = '{8'h63, 8'h67, 8'h67, 8'h6b, 8'h67, 8'h6b};
  localparam source_t RL [6] = '{SRC_MONO, SRC_SAP, SRC_MONO, SRC_STEREO, SRC_SAP, SRC_STEREO};
  localparam source_t RR [6] = '{SRC_MONO, SRC_SAP, SRC_SAP, SRC_STEREO, SRC_SAP, SRC_STEREO};
  localparam source_t RN [6] = '{SRC_MONO, SRC_SAP, SRC_SAP, SRC_EXT_SAP, SRC_MONO, SRC_MONO};
  // open drain wire with pull-up
  assign sda = ~(dev_oe | host_oe);
  always #20 core_clk = ~core_clk;
  tv_sound_host u_host (.core_clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  tv_sound_control_registers uut (.core_clk_i(core_clk), .rst_n_i(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(dev_oe), .pilot_present_i(pilot),
    .second_program_present_i(sap), .noise_present_i(noise),
    .input_level_trim_o(trim[0]), .stereo_osc_trim_o(trim[1]), .filter_trim_o(trim[2]),
    .low_band_sep_trim_o(trim[3]), .high_band_sep_trim_o(trim[4]),
    .second_program_osc_trim_o(trim[5]), .pilot_cancel_en_o(pce),
    .left_audio_out_sel_o(lft), .right_audio_out_sel_o(rgt), .normal_out_sel_o(nrm),
    .detection_status_o(status));
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_src(input source_t got, input source_t exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: select %h, wanted %h", $time, got, exp);
    end
  endtask : cmp_src
  task automatic put(input logic [7:0] sub, input logic [7:0] d [$]);
    u_host.write_regs(7'h47, sub, d, ok);
    cmp_val({7'h0, ok}, 8'h01);
    repeat (4) @(negedge core_clk);
  endtask : put
  task automatic t_reset;
    cmp_src(lft, SRC_MUTE);
    cmp_src(nrm, SRC_MUTE);
    cmp_val(status, 8'h83);
    cmp_val({7'h0, sda_out}, 8'h00);
    u_host.read_reg(7'h47, rd, ok);
    cmp_val({7'h0, ok}, 8'h01);
    cmp_val(rd, 8'h83);
    u_host.read_reg(7'h47, rd, ok);
    cmp_val(rd, 8'h03);
  endtask : t_reset
  task automatic t_defaults;
    put(8'h00, {8'h20, 8'h20, 8'h3f, 8'h20, 8'h20, 8'h20, 8'h01});
    for (int i = 0; i < 6; i++) cmp_val({2'h0, trim[i]}, (i == 2) ? 8'h3f : 8'h20);
    cmp_val({7'h0, pce}, 8'h01);
  endtask : t_defaults
  task automatic t_routing;
    pilot = 1'h1;
    sap = 1'h1;
    for (int i = 0; i < 6; i++) begin
      put(8'h06, {RW[i]});
      cmp_src(lft, RL[i]);
      cmp_src(rgt, RR[i]);
      cmp_src(nrm, RN[i]);
      cmp_val(status, RS[i]);
    end
  endtask : t_routing
  task automatic t_noise;
    put(8'h06, {8'h05});
    noise = 1'h1;
    repeat (4) @(negedge core_clk);
    cmp_src(lft, SRC_MONO);
    put(8'h06, {8'h01});
    cmp_src(lft, SRC_STEREO);
    cmp_val(status, 8'h5b);
    put(8'h00, {8'h60});
    cmp_src(lft, SRC_MONO);
    cmp_val(status, 8'h13);
    noise = 1'h0;
    repeat (4) @(negedge core_clk);
    cmp_src(lft, SRC_STEREO);
  endtask : t_noise
  task automatic t_monitor;
    put(8'h01, {8'h60});
    cmp_src(rgt, SRC_FH_MON);
    put(8'h01, {8'h20, 8'h7f, 8'h20, 8'h20, 8'h60});
    cmp_src(rgt, SRC_FH5_MON);
    cmp_val({7'h0, pce}, 8'h00);
    put(8'h06, {8'h00});
    cmp_src(rgt, SRC_MUTE);
  endtask : t_monitor
  task automatic t_bad_addr;
    u_host.write_regs(7'h45, 8'h00, {8'h11}, ok);
    cmp_val({7'h0, ok}, 8'h00);
    cmp_val({2'h0, trim[0]}, 8'h20);
  endtask : t_bad_addr
  task automatic print_verdict;
    $display("errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge core_clk);
    t_reset;
    t_defaults;
    t_routing;
    t_noise;
    t_monitor;
    t_bad_addr;
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire

// [tb/tv_sound_chk.sv]
// assertion checker for the sound control register bank
`timescale 1ns/100ps
`default_nettype none
module tv_sound_chk
  import tv_sound_pkg::*;
(
  // clock, reset and pins
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  input wire logic       pilot_present_i,
  input wire logic       noise_present_i,
  // selects and status
  input wire source_t    left_audio_out_sel_o,
  input wire source_t    right_audio_out_sel_o,
  input wire source_t    normal_out_sel_o,
  input wire logic [7:0] detection_status_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_noise; noise_present_i [*4]; endsequence
  sequence s_pilot; (pilot_present_i && !noise_present_i) [*4]; endsequence
  sequence s_scl_high; scl_i [*3]; endsequence
  property p_mute;
    left_audio_out_sel_o == SRC_MUTE |->
      right_audio_out_sel_o == SRC_MUTE && normal_out_sel_o == SRC_MUTE;
  endproperty
  property p_ones; detection_status_o[1:0] == 2'h3; endproperty
  property p_noise; s_noise |-> detection_status_o[4]; endproperty
  property p_pilot; s_pilot |-> detection_status_o[6]; endproperty
  property p_st_rx;
    detection_status_o[3] |-> detection_status_o[6] && !detection_status_o[2];
  endproperty
  property p_sap_rx; detection_status_o[2] |-> detection_status_o[5]; endproperty
  property p_second_program_both_channels;
    left_audio_out_sel_o == SRC_SAP |->
      right_audio_out_sel_o inside {SRC_SAP, SRC_FH_MON, SRC_FH5_MON};
  endproperty
  property p_bus; s_scl_high |-> $stable(sda_oe_o); endproperty
  a_mute: assert property (p_mute) else $error("mute not on all outputs");
  a_ones: assert property (p_ones) else $error("status low bits not one");
  a_noise: assert property (p_noise) else $error("noise flag missing");
  a_pilot: assert property (p_pilot) else $error("pilot flag missing");
  a_st_rx: assert property (p_st_rx) else $error("stereo reception wrong");
  a_sap_rx: assert property (p_sap_rx) else $error("sap reception wrong");
  a_second_program_both_channels: assert property (p_second_program_both_channels) else $error("sap variant wrong");
  a_bus: assert property (p_bus) else $error("data moved while clock high");
endmodule : tv_sound_chk
bind tv_sound_control_registers tv_sound_chk u_chk (.core_clk_i, .rst_n_i, .scl_i,
  .sda_oe_o, .pilot_present_i, .noise_present_i, .left_audio_out_sel_o,
  .right_audio_out_sel_o, .normal_out_sel_o, .detection_status_o);
`default_nettype wire

// [tb/tv_sound_host.sv]
// serial bus host model for the two-wire control bus
`timescale 1ns/100ps
`default_nettype none
module tv_sound_host
(
  // timing reference
  input  wire logic core_clk_i,
  // bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  // one bit, data set while clock low
  task automatic bit_slot(input logic b, output logic s);
    sda_oe_o = ~b;
    tick(2);
    scl_o = 1'h1;
    tick(2);
    s = sda_i;
    tick(2);
    scl_o = 1'h0;
    tick(2);
  endtask : bit_slot
  task automatic start_cond;
    sda_oe_o = 1'h0;
    tick(2);
    scl_o = 1'h1;
    tick(2);
    sda_oe_o = 1'h1;
    tick(2);
    scl_o = 1'h0;
    tick(2);
  endtask : start_cond
  task automatic stop_cond;
    sda_oe_o = 1'h1;
    tick(2);
    scl_o = 1'h1;
    tick(2);
    sda_oe_o = 1'h0;
    tick(4);
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'h1, s);
    ack = ~s;
  endtask : put_byte
  task automatic write_regs(input logic [6:0] a, input logic [7:0] sub,
                            input logic [7:0] d [$], output logic ok);
    logic ack;
    start_cond();
    put_byte({a, 1'h0}, ok);
    put_byte(sub, ack);
    ok = ok & ack;
    foreach (d[i]) begin
      put_byte(d[i], ack);
      ok = ok & ack;
    end
    stop_cond();
  endtask : write_regs
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    logic s;
    start_cond();
    put_byte({a, 1'h1}, ok);
    for (int i = 7; i >= 0; i--) bit_slot(1'h1, d[i]);
    bit_slot(1'h1, s);
    stop_cond();
  endtask : read_reg
endmodule : tv_sound_host
`default_nettype wire
